//--- include/irq_ctrl_pkg.sv
/*
 outbound interrupt controller package: sizes, source indices, register
 word indices, reset values, trigger modes and the bus request carrier.
 assumes a 32-bit avalon-mm slave port with byte address, word aligned.
*/
//Behaviour
//- indices 0-2 are the three aggregates
//- pin inputs become sources 3 and 4
//- frame dma 28, integrity monitor 32
//- sources 40-49 from ten software bits
//- exactly two destinations, each on a pin and inband
//- everything inside is active high
//- raw read shows live source level
//- level mode sets sticky while active
//- any-edge mode sets sticky on change
//- falling mode sets sticky on fall
//- rising mode sets sticky on rise
//- write one clears sticky, zero keeps
//- set wins over simultaneous clear
//- forward only when sticky (raw if bypassed) and enabled
//- identify shows active and enabled sources
//- bypass uses raw level, ignores latch
//- force register injects debug events
//- atomic enable clear and set registers
//- each aggregate has its own register set
//- per destination pending view readable
//- pin output drive mode and polarities
//- per destination source mask gates propagation
//- drive 0 continuous, 1 open collector
//- aggregate is or of module identifies
package irq_ctrl_pkg;
	localparam int SRC_N   = 50;
	localparam int MOD_N   = 32;
	localparam int AGG_N   = 3;
	localparam int DST_N   = 2;
	localparam int ADDR_W  = 8;
	localparam int DATA_W  = 32;
	localparam int SW_N    = 10;

	// source indices
	localparam int SRC_PORT_AGG  = 0;
	localparam int SRC_SIX_AGG   = 1;
	localparam int SRC_TEN_AGG   = 2;
	localparam int SRC_PIN0      = 3;
	localparam int SRC_PIN1      = 4;
	localparam int SRC_FRAME_DMA = 28;
	localparam int SRC_INTEGRITY = 32;
	localparam int SRC_SW_LO     = 40;

	// indices fed from the generic peripheral input bus
	localparam logic [63:0] PERIPH_MASK = 64'h0000_00ee_efff_ffc0;
	localparam logic [63:0] SRC_VALID   = 64'h0003_ffff_ffff_ffff;

	// main bank word indices, pairs are low word then high word
	localparam logic [5:0] W_RAW      = 6'h00;
	localparam logic [5:0] W_BYPASS   = 6'h02;
	localparam logic [5:0] W_TRIG     = 6'h04;
	localparam logic [5:0] W_FORCE    = 6'h08;
	localparam logic [5:0] W_STICKY   = 6'h0a;
	localparam logic [5:0] W_ENA      = 6'h0c;
	localparam logic [5:0] W_ENA_CLR  = 6'h0e;
	localparam logic [5:0] W_ENA_SET  = 6'h10;
	localparam logic [5:0] W_IDENT    = 6'h12;
	localparam logic [5:0] W_MAP      = 6'h14;
	localparam logic [5:0] W_DIDENT   = 6'h18;
	localparam logic [5:0] W_SW_RAISE = 6'h1c;
	localparam logic [5:0] W_PIN_IPOL = 6'h1d;
	localparam logic [5:0] W_PIN_OPOL = 6'h1e;
	localparam logic [5:0] W_PIN_DRV  = 6'h1f;
	localparam logic [5:0] W_AGG_BASE = 6'h20;

	// register offsets inside one aggregate bank
	localparam logic [2:0] A_POL    = 3'h0;
	localparam logic [2:0] A_RAW    = 3'h1;
	localparam logic [2:0] A_BYPASS = 3'h2;
	localparam logic [2:0] A_TRIG   = 3'h3;
	localparam logic [2:0] A_TRIG_HI = 3'h4;
	localparam logic [2:0] A_STICKY = 3'h5;
	localparam logic [2:0] A_ENA    = 3'h6;
	localparam logic [2:0] A_IDENT  = 3'h7;

	// reset values
	localparam logic [63:0]  RST_VEC64  = 64'h0;
	localparam logic [127:0] RST_TRIG   = 128'h0;
	localparam logic [31:0]  RST_VEC32  = 32'h0;
	localparam logic [1:0]   RST_PIN    = 2'h0;
	localparam logic [9:0]   RST_SW     = 10'h0;

	typedef enum logic [1:0] {
		TRIG_LEVEL,
		TRIG_ANY,
		TRIG_FALL,
		TRIG_RISE
	} trig_mode_t;

	typedef struct packed {
		logic              read;
		logic              write;
		logic [ADDR_W-1:0] address;
		logic [DATA_W-1:0] writedata;
		logic [3:0]        byteenable;
	} avl_req_t;
endpackage

//--- rtl/outbound_irq_ctrl.sv
/*
 outbound interrupt controller: fifty sources with raw, sticky, trigger,
 bypass, force, enable and identify logic, three aggregated module
 hierarchies, and two destinations out on pins and as inband levels.
 assumes sources synchronous to i_clk and an avalon-mm master that holds
 its request until waitrequest is seen low.
*/
`timescale 1ns/1ns
module outbound_irq_ctrl (
	input  wire logic                         i_clk,
	input  wire logic                         i_reset_n,
	input  wire irq_ctrl_pkg::avl_req_t       i_avl,
	output logic [irq_ctrl_pkg::DATA_W-1:0]   o_readdata,
	output logic                              o_waitrequest,
	input  wire logic [irq_ctrl_pkg::MOD_N-1:0] i_port_module_irq,
	input  wire logic [irq_ctrl_pkg::MOD_N-1:0] i_six_gig_irq,
	input  wire logic [irq_ctrl_pkg::MOD_N-1:0] i_ten_gig_irq,
	input  wire logic [1:0]                   i_pin_input_irq,
	input  wire logic                         i_frame_dma_irq,
	input  wire logic                         i_memory_integrity_irq,
	input  wire logic [63:0]                  i_periph_irq,
	output logic [1:0]                        o_pin_output_irq,
	output logic [1:0]                        o_pin_output_irq_oe,
	output logic [1:0]                        o_inband_irq
);
	// bus handshake
	logic        waitreq_reg;
	logic [31:0] rdata_reg;
	logic        wr_acc;
	logic [5:0]  widx;
	logic        whi;
	logic [31:0] wmask;
	logic [31:0] wbits;
	logic [31:0] rd_word;
	// main bank state
	logic [63:0]  bypass_reg;
	logic [127:0] trig_reg;
	logic [63:0]  sticky_reg;
	logic [63:0]  ena_reg;
	logic [63:0]  prev_reg;
	logic [63:0]  map_reg [irq_ctrl_pkg::DST_N];
	logic [9:0]   sw_raise_reg;
	logic [1:0]   pin_ipol_reg;
	logic [1:0]   pin_opol_reg;
	logic [1:0]   pin_drv_reg;
	// main bank combinational
	logic [63:0] src_raw;
	logic [63:0] src_hits;
	logic [63:0] fwd;
	logic [63:0] ident;
	logic [63:0] dident [irq_ctrl_pkg::DST_N];
	logic [1:0]  dst_any;
	logic [1:0]  pin_in;
	logic [63:0] force_ones;
	logic [63:0] clr_ones;
	logic [63:0] ena_clr_ones;
	logic [63:0] ena_set_ones;
	// aggregate hierarchies
	logic [31:0] mod_in     [irq_ctrl_pkg::AGG_N];
	logic [31:0] agg_pol_reg [irq_ctrl_pkg::AGG_N];
	logic [31:0] agg_byp_reg [irq_ctrl_pkg::AGG_N];
	logic [63:0] agg_trig_reg [irq_ctrl_pkg::AGG_N];
	logic [31:0] agg_stk_reg [irq_ctrl_pkg::AGG_N];
	logic [31:0] agg_ena_reg [irq_ctrl_pkg::AGG_N];
	logic [31:0] agg_prev_reg [irq_ctrl_pkg::AGG_N];
	logic [31:0] agg_raw    [irq_ctrl_pkg::AGG_N];
	logic [31:0] agg_ident  [irq_ctrl_pkg::AGG_N];
	logic [2:0]  agg_src;
	function automatic logic [63:0] edge_hits(
		input logic [63:0]  cur,
		input logic [63:0]  prev,
		input logic [127:0] mode
	);
		logic [63:0] h;
		h = '0;
		for (int i = 0; i < 64; i++) begin
			case (irq_ctrl_pkg::trig_mode_t'(mode[2*i +: 2]))
				irq_ctrl_pkg::TRIG_LEVEL: h[i] = cur[i];
				irq_ctrl_pkg::TRIG_ANY:   h[i] = cur[i] ^ prev[i];
				irq_ctrl_pkg::TRIG_FALL:  h[i] = prev[i] & ~cur[i];
				default:                  h[i] = cur[i] & ~prev[i];
			endcase
		end
		return h;
	endfunction
	// write one half of a 64-bit register under byte enables
	function automatic logic [63:0] put64(
		input logic [63:0] old,
		input logic        hi,
		input logic [31:0] wd,
		input logic [31:0] wm
	);
		logic [63:0] r;
		r = old;
		if (hi) begin
			r[63:32] = (old[63:32] & ~wm) | (wd & wm);
		end else begin
			r[31:0] = (old[31:0] & ~wm) | (wd & wm);
		end
		return r;
	endfunction

	function automatic logic [63:0] ones64(
		input logic        hit,
		input logic        hi,
		input logic [31:0] wb
	);
		logic [63:0] r;
		r = '0;
		if (hit) begin
			r = hi ? {wb, 32'h0} : {32'h0, wb};
		end
		return r & irq_ctrl_pkg::SRC_VALID;
	endfunction

	assign wr_acc = i_avl.write & ~waitreq_reg;
	assign widx   = i_avl.address[7:2];
	assign whi    = widx[0];
	assign wmask  = {{8{i_avl.byteenable[3]}}, {8{i_avl.byteenable[2]}},
	                 {8{i_avl.byteenable[1]}}, {8{i_avl.byteenable[0]}}};
	assign wbits  = i_avl.writedata & wmask;

	// one wait cycle, then waitrequest low for exactly one edge
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			waitreq_reg <= 1'b1;
		end else begin
			waitreq_reg <= ~((i_avl.read | i_avl.write) & waitreq_reg);
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rdata_reg <= irq_ctrl_pkg::RST_VEC32;
		end else if ((i_avl.read | i_avl.write) & waitreq_reg) begin
			rdata_reg <= i_avl.read ? rd_word : 32'h0;
		end
	end
	assign o_readdata    = rdata_reg;
	assign o_waitrequest = waitreq_reg;
	// polarity on the pins happens before entry; bit 0 = active low
	assign pin_in = ~(i_pin_input_irq ^ pin_ipol_reg);

	// source assembly
	always_comb begin
		src_raw = i_periph_irq & irq_ctrl_pkg::PERIPH_MASK;
		src_raw[irq_ctrl_pkg::SRC_PORT_AGG] = agg_src[0];
		src_raw[irq_ctrl_pkg::SRC_SIX_AGG]  = agg_src[1];
		src_raw[irq_ctrl_pkg::SRC_TEN_AGG]  = agg_src[2];
		src_raw[irq_ctrl_pkg::SRC_PIN0]     = pin_in[0];
		src_raw[irq_ctrl_pkg::SRC_PIN1]     = pin_in[1];
		src_raw[irq_ctrl_pkg::SRC_FRAME_DMA] = i_frame_dma_irq;
		src_raw[irq_ctrl_pkg::SRC_INTEGRITY] = i_memory_integrity_irq;
		src_raw[irq_ctrl_pkg::SRC_SW_LO +: irq_ctrl_pkg::SW_N] =
			sw_raise_reg;
	end
	assign src_hits = edge_hits(src_raw, prev_reg, trig_reg);
	assign fwd      = (bypass_reg & src_raw) | (~bypass_reg & sticky_reg);
	assign ident    = fwd & ena_reg & irq_ctrl_pkg::SRC_VALID;
	assign force_ones   = ones64(wr_acc && widx[5:1] == irq_ctrl_pkg::W_FORCE[5:1],
	                             whi, wbits);
	assign clr_ones     = ones64(wr_acc && widx[5:1] == irq_ctrl_pkg::W_STICKY[5:1],
	                             whi, wbits);
	assign ena_clr_ones = ones64(wr_acc && widx[5:1] == irq_ctrl_pkg::W_ENA_CLR[5:1],
	                             whi, wbits);
	assign ena_set_ones = ones64(wr_acc && widx[5:1] == irq_ctrl_pkg::W_ENA_SET[5:1],
	                             whi, wbits);

	// previous copy for edge detection
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			prev_reg <= irq_ctrl_pkg::RST_VEC64;
		end else begin
			prev_reg <= src_raw;
		end
	end
	// sticky: hit and force are or-ed after the clear so the set wins
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sticky_reg <= irq_ctrl_pkg::RST_VEC64;
		end else begin
			sticky_reg <= ((sticky_reg & ~clr_ones)
			              | src_hits | force_ones)
			              & irq_ctrl_pkg::SRC_VALID;
		end
	end
	// enable with atomic set and clear; set wins if both hit one bit
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ena_reg <= irq_ctrl_pkg::RST_VEC64;
		end else if (wr_acc && widx[5:1] == irq_ctrl_pkg::W_ENA[5:1]) begin
			ena_reg <= put64(ena_reg, whi, i_avl.writedata, wmask)
			           & irq_ctrl_pkg::SRC_VALID;
		end else begin
			ena_reg <= (ena_reg & ~ena_clr_ones) | ena_set_ones;
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			bypass_reg <= irq_ctrl_pkg::RST_VEC64;
		end else if (wr_acc && widx[5:1] == irq_ctrl_pkg::W_BYPASS[5:1]) begin
			bypass_reg <= put64(bypass_reg, whi, i_avl.writedata, wmask)
			              & irq_ctrl_pkg::SRC_VALID;
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			trig_reg <= irq_ctrl_pkg::RST_TRIG;
		end else if (wr_acc && widx[5:2] == irq_ctrl_pkg::W_TRIG[5:2]) begin
			trig_reg[32*widx[1:0] +: 32] <=
				(trig_reg[32*widx[1:0] +: 32] & ~wmask) | wbits;
		end
	end

	// destination masks, one pair of words each
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			map_reg[0] <= irq_ctrl_pkg::RST_VEC64;
			map_reg[1] <= irq_ctrl_pkg::RST_VEC64;
		end else if (wr_acc && widx[5:2] == irq_ctrl_pkg::W_MAP[5:2]) begin
			map_reg[widx[1]] <= put64(map_reg[widx[1]], whi,
			                          i_avl.writedata, wmask)
			                    & irq_ctrl_pkg::SRC_VALID;
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sw_raise_reg <= irq_ctrl_pkg::RST_SW;
		end else if (wr_acc && widx == irq_ctrl_pkg::W_SW_RAISE) begin
			sw_raise_reg <= (sw_raise_reg & ~wmask[9:0]) | wbits[9:0];
		end
	end

	// pin polarity and drive mode
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pin_ipol_reg <= irq_ctrl_pkg::RST_PIN;
			pin_opol_reg <= irq_ctrl_pkg::RST_PIN;
			pin_drv_reg  <= irq_ctrl_pkg::RST_PIN;
		end else if (wr_acc && i_avl.byteenable[0]) begin
			if (widx == irq_ctrl_pkg::W_PIN_IPOL) begin
				pin_ipol_reg <= i_avl.writedata[1:0];
			end else if (widx == irq_ctrl_pkg::W_PIN_OPOL) begin
				pin_opol_reg <= i_avl.writedata[1:0];
			end else if (widx == irq_ctrl_pkg::W_PIN_DRV) begin
				pin_drv_reg <= i_avl.writedata[1:0];
			end
		end
	end

	// destination logic, one per destination
	genvar d;
	generate
		for (d = 0; d < irq_ctrl_pkg::DST_N; d++) begin : g_dst
			assign dident[d]  = ident & map_reg[d];
			assign dst_any[d] = |dident[d];
		end
	endgenerate

	// outputs leave through flops; pin polarity applied before exit, inband has none
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_pin_output_irq    <= 2'h0;
			o_pin_output_irq_oe <= 2'h0;
			o_inband_irq        <= 2'h0;
		end else begin
			o_inband_irq <= dst_any;
			for (int e = 0; e < irq_ctrl_pkg::DST_N; e++) begin
				if (pin_drv_reg[e]) begin
					// open collector: drive only the asserted level
					o_pin_output_irq[e]    <= pin_opol_reg[e];
					o_pin_output_irq_oe[e] <= dst_any[e];
				end else begin
					o_pin_output_irq[e]    <= ~(dst_any[e] ^ pin_opol_reg[e]);
					o_pin_output_irq_oe[e] <= 1'b1;
				end
			end
		end
	end
	// aggregated module hierarchies
	assign mod_in[0] = i_port_module_irq;
	assign mod_in[1] = i_six_gig_irq;
	assign mod_in[2] = i_ten_gig_irq;
	genvar h;
	generate
		for (h = 0; h < irq_ctrl_pkg::AGG_N; h++) begin : g_agg
			logic        a_sel;
			logic [31:0] a_hits;
			logic [63:0] a_hits64;
			logic [31:0] a_clr;
			assign a_sel = wr_acc && widx[5] && (widx[4:3] == 2'(h));
			// polarity bit set inverts the module input
			assign agg_raw[h] = mod_in[h] ^ agg_pol_reg[h];
			assign a_hits64 = edge_hits({32'h0, agg_raw[h]},
			                            {32'h0, agg_prev_reg[h]},
			                            {64'h0, agg_trig_reg[h]});
			assign a_hits = a_hits64[31:0];
			assign a_clr  = (a_sel && widx[2:0] == irq_ctrl_pkg::A_STICKY)
			                ? wbits : 32'h0;
			assign agg_ident[h] = ((agg_byp_reg[h] & agg_raw[h])
			                      | (~agg_byp_reg[h] & agg_stk_reg[h]))
			                      & agg_ena_reg[h];
			assign agg_src[h] = |agg_ident[h];
			always_ff @(posedge i_clk or negedge i_reset_n) begin
				if (!i_reset_n) begin
					agg_prev_reg[h] <= irq_ctrl_pkg::RST_VEC32;
					agg_stk_reg[h]  <= irq_ctrl_pkg::RST_VEC32;
				end else begin
					agg_prev_reg[h] <= agg_raw[h];
					agg_stk_reg[h]  <= (agg_stk_reg[h] & ~a_clr) | a_hits;
				end
			end
			always_ff @(posedge i_clk or negedge i_reset_n) begin
				if (!i_reset_n) begin
					agg_pol_reg[h]  <= irq_ctrl_pkg::RST_VEC32;
					agg_byp_reg[h]  <= irq_ctrl_pkg::RST_VEC32;
					agg_ena_reg[h]  <= irq_ctrl_pkg::RST_VEC32;
					agg_trig_reg[h] <= irq_ctrl_pkg::RST_VEC64;
				end else if (a_sel) begin
					if (widx[2:0] == irq_ctrl_pkg::A_POL) begin
						agg_pol_reg[h] <= (agg_pol_reg[h] & ~wmask) | wbits;
					end else if (widx[2:0] == irq_ctrl_pkg::A_BYPASS) begin
						agg_byp_reg[h] <= (agg_byp_reg[h] & ~wmask) | wbits;
					end else if (widx[2:0] == irq_ctrl_pkg::A_ENA) begin
						agg_ena_reg[h] <= (agg_ena_reg[h] & ~wmask) | wbits;
					end else if (widx[2:0] == irq_ctrl_pkg::A_TRIG ||
					             widx[2:0] == irq_ctrl_pkg::A_TRIG_HI) begin
						// high trigger word is the one with offset bit 2 set
						agg_trig_reg[h] <= put64(agg_trig_reg[h], widx[2],
						                         i_avl.writedata, wmask);
					end
				end
			end
		end
	endgenerate
	// read mux; unmapped words read zero
	always_comb begin
		logic [63:0] v;
		logic [2:0]  a;
		logic [1:0]  hs;
		v  = 64'h0;
		a  = widx[2:0];
		hs = widx[4:3];
		rd_word = 32'h0;
		if (widx[5]) begin
			if (hs == 2'h3) begin
				rd_word = 32'h0;
			end else if (a == irq_ctrl_pkg::A_POL) begin
				rd_word = agg_pol_reg[hs];
			end else if (a == irq_ctrl_pkg::A_RAW) begin
				rd_word = agg_raw[hs];
			end else if (a == irq_ctrl_pkg::A_BYPASS) begin
				rd_word = agg_byp_reg[hs];
			end else if (a == irq_ctrl_pkg::A_TRIG) begin
				rd_word = agg_trig_reg[hs][31:0];
			end else if (a == irq_ctrl_pkg::A_TRIG_HI) begin
				rd_word = agg_trig_reg[hs][63:32];
			end else if (a == irq_ctrl_pkg::A_STICKY) begin
				rd_word = agg_stk_reg[hs];
			end else if (a == irq_ctrl_pkg::A_ENA) begin
				rd_word = agg_ena_reg[hs];
			end else begin
				rd_word = agg_ident[hs];
			end
		end else begin
			if (widx[5:1] == irq_ctrl_pkg::W_RAW[5:1]) begin
				v = src_raw;
			end else if (widx[5:1] == irq_ctrl_pkg::W_BYPASS[5:1]) begin
				v = bypass_reg;
			end else if (widx[5:1] == irq_ctrl_pkg::W_STICKY[5:1]) begin
				v = sticky_reg;
			end else if (widx[5:1] == irq_ctrl_pkg::W_ENA[5:1]) begin
				v = ena_reg;
			end else if (widx[5:1] == irq_ctrl_pkg::W_IDENT[5:1]) begin
				v = ident;
			end else if (widx[5:2] == irq_ctrl_pkg::W_MAP[5:2]) begin
				v = map_reg[widx[1]];
			end else if (widx[5:2] == irq_ctrl_pkg::W_DIDENT[5:2]) begin
				v = dident[widx[1]];
			end
			rd_word = whi ? v[63:32] : v[31:0];
			if (widx[5:2] == irq_ctrl_pkg::W_TRIG[5:2]) begin
				rd_word = trig_reg[32*widx[1:0] +: 32];
			end else if (widx == irq_ctrl_pkg::W_SW_RAISE) begin
				rd_word = {22'h0, sw_raise_reg};
			end else if (widx == irq_ctrl_pkg::W_PIN_IPOL) begin
				rd_word = {30'h0, pin_ipol_reg};
			end else if (widx == irq_ctrl_pkg::W_PIN_OPOL) begin
				rd_word = {30'h0, pin_opol_reg};
			end else if (widx == irq_ctrl_pkg::W_PIN_DRV) begin
				rd_word = {30'h0, pin_drv_reg};
			end
		end
	end
endmodule

//--- tb/outbound_irq_ctrl_chk.sv
/*
 bus-side and pin-side assertions for the outbound interrupt controller.
 assumes it is bound to outbound_irq_ctrl and sees only its ports.
*/
`timescale 1ns/1ns
module outbound_irq_ctrl_chk (
	input  wire logic                            i_clk,
	input  wire logic                            i_reset_n,
	input  wire irq_ctrl_pkg::avl_req_t          i_avl,
	input  wire logic [irq_ctrl_pkg::DATA_W-1:0] o_readdata,
	input  wire logic                            o_waitrequest,
	input  wire logic                            i_frame_dma_irq,
	input  wire logic                            i_memory_integrity_irq,
	input  wire logic [1:0]                      o_pin_output_irq_oe,
	input  wire logic [1:0]                      o_inband_irq
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_reset_n);

	logic       rd_ok;
	logic [5:0] wi;
	assign rd_ok = i_avl.read && !o_waitrequest;
	assign wi    = i_avl.address[7:2];

	// read accepted at one word
	sequence s_acc(w);
		rd_ok && wi == w;
	endsequence

	property p_bank3;
		rd_ok && wi[5:3] == 3'h7 |-> o_readdata == 32'h0;
	endproperty
	a_bank3: assert property (p_bank3) else $error("unmapped bank read");

	property p_raw_hi;
		s_acc(6'h01) |-> o_readdata[31:18] == 14'h0 && !o_readdata[4];
	endproperty
	a_raw_hi: assert property (p_raw_hi) else $error("raw high spare bit");

	property p_ident_hi;
		s_acc(6'h13) |-> o_readdata[31:18] == 14'h0 && !o_readdata[4];
	endproperty
	a_ident_hi: assert property (p_ident_hi) else $error("ident spare bit");

	// raw is sampled one edge before the accept edge
	property p_raw_dma;
		s_acc(6'h00) |-> o_readdata[28] == $past(i_frame_dma_irq)
			&& !o_readdata[5];
	endproperty
	a_raw_dma: assert property (p_raw_dma) else $error("raw dma bit");

	property p_raw_memory_integrity_source;
		s_acc(6'h01) |-> o_readdata[0] == $past(i_memory_integrity_irq);
	endproperty
	a_raw_memory_integrity_source: assert property (p_raw_memory_integrity_source) else $error("raw memory_integrity_source bit");

	property p_force_rd;
		rd_ok && wi[5:1] == 5'h04 |-> o_readdata == 32'h0;
	endproperty
	a_force_rd: assert property (p_force_rd) else $error("force reads");

	property p_ena_wo;
		rd_ok && (wi inside {[6'h0e:6'h11]}) |-> o_readdata == 32'h0;
	endproperty
	a_ena_wo: assert property (p_ena_wo) else $error("atomic reads");

	// released pin can only mean a quiet destination
	property p_oe_pend;
		(~o_pin_output_irq_oe & o_inband_irq) == 2'h0;
	endproperty
	a_oe_pend: assert property (p_oe_pend) else $error("released pend");
endmodule

bind outbound_irq_ctrl outbound_irq_ctrl_chk u_chk (
	.i_clk                  (i_clk),
	.i_reset_n              (i_reset_n),
	.i_avl                  (i_avl),
	.o_readdata             (o_readdata),
	.o_waitrequest          (o_waitrequest),
	.i_frame_dma_irq        (i_frame_dma_irq),
	.i_memory_integrity_irq (i_memory_integrity_irq),
	.o_pin_output_irq_oe    (o_pin_output_irq_oe),
	.o_inband_irq           (o_inband_irq)
);

//--- tb/irq_far_side.sv
/*
 far side model: frame dma source, two active-low interrupt pins and
 the board wire of the outbound pins with its pull-up.
 assumes requests come from the bench on the rising edge.
*/
`timescale 1ns/1ns
module irq_far_side (
	input  wire logic       i_clk,
	input  wire logic [2:0] i_req,
	input  wire logic [1:0] i_pin_out,
	input  wire logic [1:0] i_pin_oe,
	output logic      [1:0] o_pin_in = 2'h3,
	output logic            o_frame_dma_source = 1'b0,
	output logic      [1:0] o_wire
);
	always @(posedge i_clk) begin
		o_pin_in <= ~i_req[1:0]; // pins pulled low when asserted
		o_frame_dma_source   <= i_req[2];
	end
	// released pin floats to the pull-up, never the last level
	assign o_wire = (i_pin_oe & i_pin_out) | ~i_pin_oe;
endmodule

//--- tb/tb_outbound_interrupt_controller.sv
/*
 self-checking bench for the outbound interrupt controller.
 assumes the design answers each avalon request after one wait cycle.
*/
`timescale 1ns/1ns
module tb_outbound_interrupt_controller;
	logic                   i_clk = 1'b0;
	logic                   i_reset_n = 1'b0;
	irq_ctrl_pkg::avl_req_t avl = '0;
	logic [31:0]            mem [3] = '{32'h0, 32'h0, 32'h0};
	logic [63:0]            per = 64'h0;
	logic [2:0]             req = 3'h0;
	logic [31:0]            rdata;
	logic                   wait_req;
	logic [1:0]             pin;
	logic [1:0]             oe;
	logic [1:0]             inb;
	logic [1:0]             pin_in;
	logic [1:0]             wire_lvl;
	logic                   frame_dma_source;
	logic                   memory_integrity_source = 1'b0;
	int                     error_cnt = 0;
	int                     samples_checked = 0;

	always #25 i_clk = ~i_clk;

	outbound_irq_ctrl DUT (
		.i_clk                  (i_clk),
		.i_reset_n              (i_reset_n),
		.i_avl                  (avl),
		.o_readdata             (rdata),
		.o_waitrequest          (wait_req),
		.i_port_module_irq      (mem[0]),
		.i_six_gig_irq          (mem[1]),
		.i_ten_gig_irq          (mem[2]),
		.i_pin_input_irq        (pin_in),
		.i_frame_dma_irq        (frame_dma_source),
		.i_memory_integrity_irq (memory_integrity_source),
		.i_periph_irq           (per),
		.o_pin_output_irq       (pin),
		.o_pin_output_irq_oe    (oe),
		.o_inband_irq           (inb)
	);

	irq_far_side u_far (
		.i_clk     (i_clk),
		.i_req     (req),
		.i_pin_out (pin),
		.i_pin_oe  (oe),
		.o_pin_in  (pin_in),
		.o_frame_dma_source    (frame_dma_source),
		.o_wire    (wire_lvl)
	);

	task automatic end_of_test;
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] g,
		input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk);
	endtask

	// held until waitrequest is sampled low, then released
	task automatic bus(input logic w, input logic [5:0] wi,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		avl <= '{read: !w, write: w, address: {wi, 2'h0}, writedata: d,
			byteenable: 4'hf};
		@(posedge i_clk);
		while (wait_req !== 1'b0 && n < 50) begin
			@(posedge i_clk);
			n++;
		end
		q = rdata;
		avl <= '0;
		if (n == 50) begin
			error_cnt++;
			end_of_test();
		end
		@(posedge i_clk);
	endtask

	task automatic wr(input logic [5:0] wi, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, wi, d, q);
	endtask

	task automatic rc(input string nm, input logic [5:0] wi,
		input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, wi, 32'h0, q);
		chk(nm, q, e);
	endtask

	task automatic t_reset;
		rc("ena", 6'h0c, 32'h0);
		rc("bank3", 6'h38, 32'h0);
		chk("oe", oe, 32'h3);
		chk("pin", pin, 32'h3);
		chk("inb", inb, 32'h0);
		$display("reset test done");
	endtask

	// per mode: set after rise, after clear, after fall
	task automatic t_trig;
		logic [3:0] rise;
		logic [3:0] fall;
		rise = 4'b1011;
		fall = 4'b0111;
		for (int m = 0; m < 4; m++) begin
			wr(6'h05, 32'(m) << 24);
			wr(6'h0a, 32'h1000_0000);
			req[2] <= 1'b1;
			cyc(4);
			rc("stk_rise", 6'h0a, {3'h0, rise[m], 28'h0});
			wr(6'h0a, 32'h1000_0000);
			rc("stk_clr", 6'h0a, {3'h0, m == 0, 28'h0});
			req[2] <= 1'b0;
			cyc(4);
			rc("stk_fall", 6'h0a, {3'h0, fall[m], 28'h0});
		end
		wr(6'h05, 32'h0);
		$display("trigger test done");
	endtask

	task automatic t_route;
		wr(6'h14, 32'h1000_0000);
		wr(6'h10, 32'h1000_0000);
		req[2] <= 1'b1;
		cyc(4);
		chk("inb", inb, 32'h1);
		chk("pin", pin, 32'h2);
		rc("ident", 6'h12, 32'h1000_0000);
		rc("pend0", 6'h18, 32'h1000_0000);
		rc("pend1", 6'h1a, 32'h0);
		wr(6'h1f, 32'h1);
		cyc(3);
		chk("wire", wire_lvl, 32'h2);
		wr(6'h0e, 32'h1000_0000);
		req[2] <= 1'b0;
		cyc(3);
		chk("inb", inb, 32'h0);
		chk("oe", oe, 32'h2);
		chk("wire", wire_lvl, 32'h3);
		rc("ena", 6'h0c, 32'h0);
		rc("ena_clr", 6'h0e, 32'h0);
		wr(6'h1e, 32'h2);
		wr(6'h1f, 32'h0);
		cyc(3);
		chk("pin", pin, 32'h1);
		$display("route test done");
	endtask

	task automatic t_raw;
		per <= 64'h0000_0010_0000_0060;
		memory_integrity_source <= 1'b1;
		req[1:0] <= 2'h2;
		wr(6'h1c, 32'h201);
		cyc(3);
		rc("raw_lo", 6'h00, 32'h0000_0050);
		rc("raw_hi", 6'h01, 32'h0002_0101);
		rc("ident_hi", 6'h13, 32'h0);
		per <= 64'h0;
		memory_integrity_source <= 1'b0;
		req[1:0] <= 2'h0;
		wr(6'h1c, 32'h0);
		wr(6'h0a, 32'hffff_ffff);
		wr(6'h0b, 32'h0003_ffff);
		wr(6'h08, 32'h80);
		rc("stk_force", 6'h0a, 32'h80);
		rc("force", 6'h08, 32'h0);
		$display("raw test done");
	endtask

	task automatic t_agg;
		for (int b = 0; b < 3; b++) begin
			mem[b] <= 32'h1;
			wr(6'(38 + 8 * b), 32'h1);
			cyc(3);
			rc("agg_raw", 6'h00, 32'h1 << b);
			rc("agg_id", 6'(39 + 8 * b), 32'h1);
			mem[b] <= 32'h0;
			wr(6'(38 + 8 * b), 32'h0);
		end
		$display("aggregate test done");
	endtask

	// sticky stays set by level mode, bypass must ignore it
	task automatic t_bypass;
		wr(6'h02, 32'h1000_0000); // dma raw level forwarded, not latched
		wr(6'h10, 32'h1000_0000);
		req[2] <= 1'b1;
		cyc(4);
		chk("inb_byp", inb, 32'h1);
		req[2] <= 1'b0;
		cyc(4);
		chk("inb_byp", inb, 32'h0);
		$display("bypass test done");
	endtask

	initial begin
		cyc(10);
		i_reset_n <= 1'b1;
		t_reset();
		t_trig();
		t_route();
		t_raw();
		t_agg();
		t_bypass();
		end_of_test();
	end
endmodule
